// File: hw/conv_pkg.sv
// Purpose: Shared constants and types for the six-channel conversion control block
// Assumes: core_clk is the master clock; one modulator bit per channel arrives per modulator step
// Notes:   Field codes, ratio table and filter scaling live here
//
// Behaviour
// - Per-channel two-bit input selector, four sources
// - Eight gains 1 to 128, each channel independent
// - Full-scale range is 1.2 V over gain
// - Precharge buffer on at gain 8 and up
// - No results before reference has settled
// - Two-bit power mode rescales bias currents
// - Modulator rate is master clock halved
// - One-bit modulator stream feeds decimation filter
// - Sinc averager decimates by oversampling ratio
// - Three-bit ratio field, 128 to 16384
// - Data rate is modulator rate over ratio
// - Nominal master clock matches selected power mode
// - First two conversions use fast first-order filter
// - Ratio 2048 up: sinc3 at 1024, sinc1 rest
package conv_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CH      = 6;
    localparam int ACC_W       = 35;
    localparam int CIC_W       = 32;
    localparam int FAST_W      = 15;
    localparam int SAMPLE_W    = 24;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_PINS     = 2'h0;
    localparam logic [1:0] SEL_AGND     = 2'h1;
    localparam logic [1:0] SEL_TEST_POS = 2'h2;
    localparam logic [1:0] SEL_TEST_NEG = 2'h3;

    localparam logic [2:0] GAIN_PRECHARGE_MIN = 3'h3;
    localparam logic [2:0] RATIO_SINC3_MAX    = 3'h3;
    localparam int         RATIO_BASE_LOG2    = 7;

    typedef enum logic [1:0] {
        very_low_power_mode = 2'h0,
        low_power_mode      = 2'h1,
        high_resolution_mode = 2'h2
    } power_mode_t;

    // ------------------------------------------------------------
    // Values after reset and scaling
    // ------------------------------------------------------------
    localparam logic [20:0] FSR_GAIN_CONFIG_REGISTER_UV   = 21'h124f80;
    localparam logic [1:0]  FAST_CONV_CNT  = 2'h2;
    localparam logic [1:0]  MOD_DIV        = 2'h2;
    localparam logic [13:0] MCLK_HR_KHZ    = 14'h2000;
    localparam logic [13:0] MCLK_LP_KHZ    = 14'h1000;
    localparam logic [13:0] MCLK_VLP_KHZ   = 14'h0800;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] input_select_field;
        logic [2:0] channel_gain_field;
    } channel_config_register_t;

    typedef channel_config_register_t [NUM_CH-1:0] gain_config_register_t;

    typedef struct packed {
        logic [3:0]  route_onehot;
        logic        precharge_en;
        logic [20:0] full_scale_range_uv;
    } chan_analog_t;

    typedef chan_analog_t [NUM_CH-1:0] analog_ctrl_t;
    typedef logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_set_t;

endpackage : conv_pkg

// File: hw/chan_decim.sv
// Purpose: One channel of decimation: third-order sinc with first-order follow-on, and fast first-order path
// Assumes: step is a single-cycle enable; blk_end and conv_end are levels from the shared counters that hold between steps
// Notes:   Sums are raw; the caller normalises them
module chan_decim (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // Timing
    input  wire logic                       step,
    input  wire logic                       blk_end,
    input  wire logic                       conv_end,
    // Modulator bit
    input  wire logic                       mod_bit,
    // Results
    output logic [conv_pkg::ACC_W-1:0]      sinc3_sum_r,
    output logic [conv_pkg::FAST_W-1:0]     fast_sum_r
);
    import conv_pkg::*;

    logic [CIC_W-1:0]  int1_r;
    logic [CIC_W-1:0]  int2_r;
    logic [CIC_W-1:0]  int3_r;
    logic [CIC_W-1:0]  dly1_r;
    logic [CIC_W-1:0]  dly2_r;
    logic [CIC_W-1:0]  dly3_r;
    logic [ACC_W-1:0]  post_acc_r;
    logic [FAST_W-1:0] fast_cnt_r;
    logic [CIC_W-1:0]  int1_nxt;
    logic [CIC_W-1:0]  int2_nxt;
    logic [CIC_W-1:0]  int3_nxt;
    logic [CIC_W-1:0]  comb1;
    logic [CIC_W-1:0]  comb2;
    logic [CIC_W-1:0]  comb3;
    logic [ACC_W-1:0]  post_nxt;

    // ------------------------------------------------------------
    // Integrators and combs
    // ------------------------------------------------------------
    assign int1_nxt = int1_r + {{(CIC_W-1){1'b0}}, mod_bit};
    assign int2_nxt = int2_r + int1_nxt;
    assign int3_nxt = int3_r + int2_nxt;
    assign comb1    = int3_nxt - dly1_r;
    assign comb2    = comb1 - dly2_r;
    assign comb3    = comb2 - dly3_r;
    assign post_nxt = post_acc_r + {{(ACC_W-CIC_W){1'b0}}, comb3};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            int1_r <= '0;
            int2_r <= '0;
            int3_r <= '0;
        end else if (step) begin
            int1_r <= int1_nxt;
            int2_r <= int2_nxt;
            int3_r <= int3_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dly1_r      <= '0;
            dly2_r      <= '0;
            dly3_r      <= '0;
            post_acc_r  <= '0;
            sinc3_sum_r <= '0;
        end else if (step && blk_end) begin
            dly1_r <= int3_nxt;
            dly2_r <= comb1;
            dly3_r <= comb2;
            if (conv_end) begin
                post_acc_r  <= '0;
                sinc3_sum_r <= post_nxt;
            end else begin
                post_acc_r  <= post_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // Fast-settling first-order count over the whole ratio
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fast_cnt_r <= '0;
            fast_sum_r <= '0;
        end else if (step) begin
            if (conv_end) begin
                fast_cnt_r <= '0;
                fast_sum_r <= fast_cnt_r + {{(FAST_W-1){1'b0}}, mod_bit};
            end else begin
                fast_cnt_r <= fast_cnt_r + {{(FAST_W-1){1'b0}}, mod_bit};
            end
        end
    end

endmodule : chan_decim

// File: hw/conv_ctrl.sv
// Purpose: Channel configuration, power mode, modulator timing and decimation control
// Assumes: core_clk is the master clock; all inputs synchronous to it
// Notes:   Ratio is taken at each conversion boundary so a change never splits a conversion
module conv_ctrl (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    // Configuration
    input  conv_pkg::gain_config_register_t    chan_cfg,
    input  wire logic [1:0]                    power_mode_field,
    input  wire logic [2:0]                    oversampling_ratio_field,
    // Status from analog
    input  wire logic                          ref_settled,
    // Modulator streams
    input  wire logic [conv_pkg::NUM_CH-1:0]   mod_bits,
    // Analog control
    output conv_pkg::analog_ctrl_t             analog_ctrl_r,
    output conv_pkg::power_mode_t              bias_mode_r,
    output logic [13:0]                        nominal_mclk_khz_r,
    output logic                               mod_step,
    // Samples
    output conv_pkg::sample_set_t              samples_r,
    output logic                               sample_valid_r,
    output logic                               fast_filter_r
);
    import conv_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Selector code to one-hot analog route
    function automatic logic [3:0] route_decode(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        case (sel)
            SEL_PINS:     r = 4'h1;
            SEL_AGND:     r = 4'h2;
            SEL_TEST_POS: r = 4'h4;
            default:      r = 4'h8;
        endcase
        return r;
    endfunction : route_decode

    // Scales a raw sum whose full scale is 2**sh to a signed 24-bit code
    function automatic logic [SAMPLE_W-1:0] norm24(input logic [ACC_W-1:0] v, input logic [5:0] sh);
        logic [ACC_W:0] s;
        s = '0;
        if (sh >= 6'd24) begin
            s = {1'b0, v} >> (sh - 6'd24);
        end else begin
            s = {1'b0, v} << (6'd24 - sh);
        end
        // A full-scale sum saturates to the top code
        if (s[ACC_W:SAMPLE_W] != '0) begin
            s = {{(ACC_W-SAMPLE_W+1){1'b0}}, {SAMPLE_W{1'b1}}};
        end
        return s[SAMPLE_W-1:0] ^ {1'b1, {(SAMPLE_W-1){1'b0}}};
    endfunction : norm24

    // ------------------------------------------------------------
    // Power mode decode
    // ------------------------------------------------------------
    power_mode_t mode_dec;

    always_comb begin
        case (power_mode_field)
            2'h0:    mode_dec = very_low_power_mode;
            2'h1:    mode_dec = low_power_mode;
            default: mode_dec = high_resolution_mode;
        endcase
    end

    // Bias and nominal clock follow the decoded mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bias_mode_r        <= high_resolution_mode;
            nominal_mclk_khz_r <= MCLK_HR_KHZ;
        end else begin
            bias_mode_r <= mode_dec;
            case (mode_dec)
                very_low_power_mode: nominal_mclk_khz_r <= MCLK_VLP_KHZ;
                low_power_mode:      nominal_mclk_khz_r <= MCLK_LP_KHZ;
                default:             nominal_mclk_khz_r <= MCLK_HR_KHZ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-channel analog control
    // ------------------------------------------------------------
    // Route, precharge and range follow each channel's fields
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_analog
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    analog_ctrl_r[g] <= '{route_onehot: 4'h1, precharge_en: 1'b0,
                                          full_scale_range_uv: FSR_GAIN_CONFIG_REGISTER_UV};
                end else begin
                    analog_ctrl_r[g].route_onehot <= route_decode(chan_cfg[g].input_select_field);
                    analog_ctrl_r[g].precharge_en <=
                        (chan_cfg[g].channel_gain_field >= GAIN_PRECHARGE_MIN);
                    analog_ctrl_r[g].full_scale_range_uv <=
                        FSR_GAIN_CONFIG_REGISTER_UV >> chan_cfg[g].channel_gain_field;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Conversion state
    // ------------------------------------------------------------
    // One-hot filter path states
    typedef enum logic [2:0] {
        ST_WAIT_REF = 3'b001,
        ST_FAST     = 3'b010,
        ST_SINC3    = 3'b100
    } conv_state_t;

    conv_state_t state_r;
    logic [1:0]  fast_done_r;
    logic        running;
    logic        div_r;
    logic [2:0]  ratio_r;

    // Block and post-stage counters
    logic [9:0]  blk_cnt_r;
    logic [3:0]  post_cnt_r;
    logic [9:0]  blk_last;
    logic [3:0]  post_last;
    logic        blk_end;
    logic        conv_end;

    // Normalisation shifts
    logic [5:0]  sh_sinc3;
    logic [5:0]  sh_fast;

    assign running = (state_r != ST_WAIT_REF);

    // ------------------------------------------------------------
    // Modulator step: master clock divided by two
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    // No steps while the reference settles
    assign mod_step = div_r & running;

    // ------------------------------------------------------------
    // Decimation counters
    // ------------------------------------------------------------
    always_comb begin
        // Above 1024 the sinc3 block is fixed and blocks are summed
        if (ratio_r > RATIO_SINC3_MAX) begin
            blk_last  = 10'h3ff;
            post_last = 4'((5'h1 << (ratio_r - RATIO_SINC3_MAX)) - 5'h1);
        end else begin
            blk_last  = 10'((11'h80 << ratio_r) - 11'h1);
            post_last = 4'h0;
        end
    end

    // Boundary strobes, valid only with mod_step
    assign blk_end  = (blk_cnt_r == blk_last);
    assign conv_end = blk_end && (post_cnt_r == post_last);

    // Ratio follows the field until running, then reloads only at a conversion boundary
    always_ff @(posedge core_clk) begin
        if (rst || !running) begin
            blk_cnt_r  <= '0;
            post_cnt_r <= '0;
            ratio_r    <= oversampling_ratio_field;
        end else if (mod_step) begin
            if (blk_end) begin
                blk_cnt_r <= '0;
                if (conv_end) begin
                    post_cnt_r <= '0;
                    ratio_r    <= oversampling_ratio_field;
                end else begin
                    post_cnt_r <= post_cnt_r + 4'h1;
                end
            end else begin
                blk_cnt_r <= blk_cnt_r + 10'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Filter path selection
    // ------------------------------------------------------------
    // Fast path for two conversions, then sinc3 until reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r     <= ST_WAIT_REF;
            fast_done_r <= '0;
        end else begin
            case (state_r)
                ST_WAIT_REF: begin
                    if (ref_settled) begin
                        state_r <= ST_FAST;
                    end
                end
                ST_FAST: begin
                    if (mod_step && conv_end) begin
                        fast_done_r <= fast_done_r + 2'h1;
                        if (fast_done_r + 2'h1 == FAST_CONV_CNT) begin
                            state_r <= ST_SINC3;
                        end
                    end
                end
                ST_SINC3: state_r <= ST_SINC3;
                default:  state_r <= ST_WAIT_REF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Channel filters
    // ------------------------------------------------------------
    logic [NUM_CH-1:0][ACC_W-1:0]  sinc3_sum;
    logic [NUM_CH-1:0][FAST_W-1:0] fast_sum;
    logic                          result_due_r;
    logic                          use_fast_r;
    logic [2:0]                    out_ratio_r;

    // Filters stay cleared until running
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_chan
            chan_decim u_decim (
                .core_clk    (core_clk),
                .rst         (rst || !running),
                .step        (mod_step),
                .blk_end     (blk_end),
                .conv_end    (conv_end),
                .mod_bit     (mod_bits[g]),
                .sinc3_sum_r (sinc3_sum[g]),
                .fast_sum_r  (fast_sum[g])
            );
        end
    endgenerate

    // Sums land one cycle after the conversion boundary
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_due_r <= 1'b0;
            use_fast_r   <= 1'b1;
            out_ratio_r  <= '0;
        end else begin
            result_due_r <= mod_step && conv_end;
            if (mod_step && conv_end) begin
                use_fast_r  <= (state_r == ST_FAST);
                out_ratio_r <= ratio_r;
            end
        end
    end

    // Fast full scale is the ratio, sinc3 the cube of its block times the number of blocks
    always_comb begin
        sh_fast = 6'(RATIO_BASE_LOG2) + {3'h0, out_ratio_r};
        if (out_ratio_r > RATIO_SINC3_MAX) begin
            sh_sinc3 = 6'(3 * (RATIO_BASE_LOG2 + 3)) + {3'h0, out_ratio_r - RATIO_SINC3_MAX};
        end else begin
            sh_sinc3 = 6'd3 * (6'(RATIO_BASE_LOG2) + {3'h0, out_ratio_r});
        end
    end

    generate
        for (g = 0; g < NUM_CH; g++) begin : g_out
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    samples_r[g] <= '0;
                end else if (result_due_r) begin
                    if (use_fast_r) begin
                        samples_r[g] <= norm24({{(ACC_W-FAST_W){1'b0}}, fast_sum[g]}, sh_fast);
                    end else begin
                        samples_r[g] <= norm24(sinc3_sum[g], sh_sinc3);
                    end
                end
            end
        end
    endgenerate

    // Valid and path flag travel with the samples
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sample_valid_r <= 1'b0;
            fast_filter_r  <= 1'b1;
        end else begin
            sample_valid_r <= result_due_r;
            if (result_due_r) begin
                fast_filter_r <= use_fast_r;
            end
        end
    end

endmodule : conv_ctrl

// File: verif/conv_ctrl_checker.sv
// Purpose: Port-level assertions for the conversion control block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound onto conv_ctrl below
module conv_ctrl_checker (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // Configuration and status
    input  conv_pkg::gain_config_register_t  chan_cfg,
    input  wire logic [1:0]                  power_mode_field,
    input  wire logic                        ref_settled,
    // Outputs under watch
    input  conv_pkg::analog_ctrl_t           analog_ctrl_r,
    input  conv_pkg::power_mode_t            bias_mode_r,
    input  wire logic [13:0]                 nominal_mclk_khz_r,
    input  wire logic                        mod_step,
    input  wire logic                        sample_valid_r,
    input  wire logic                        fast_filter_r
);
    import conv_pkg::*;

    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic       seen_r;
    logic [1:0] vcnt_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            seen_r <= 1'b0;
        end else if (ref_settled) begin
            seen_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            vcnt_r <= 2'h0;
        end else if (sample_valid_r && vcnt_r != 2'h3) begin
            vcnt_r <= vcnt_r + 2'h1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence alt_step_s;
        ##1 !mod_step ##1 mod_step;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    route_select_a: assert property (!$past(rst) |-> analog_ctrl_r[0].route_onehot ==
        (4'h1 << $past(chan_cfg[0].input_select_field))) else $error("input route wrong");
    fsr_scale_a: assert property (!$past(rst) |-> analog_ctrl_r[5].full_scale_range_uv ==
        (FSR_GAIN_CONFIG_REGISTER_UV >> $past(chan_cfg[5].channel_gain_field))) else $error("range wrong");
    gain_precharge_a: assert property (!$past(rst) |-> analog_ctrl_r[2].precharge_en ==
        ($past(chan_cfg[2].channel_gain_field) > 3'h2)) else $error("precharge wrong");
    bias_mode_a: assert property (!$past(rst) |-> bias_mode_r ==
        (($past(power_mode_field) == 2'h3) ? high_resolution_mode : power_mode_t'($past(power_mode_field))))
        else $error("bias mode wrong");
    mclk_nominal_a: assert property (!$past(rst) |-> nominal_mclk_khz_r ==
        (($past(power_mode_field) == 2'h0) ? 14'h0800 : ($past(power_mode_field) == 2'h1) ? 14'h1000 : 14'h2000))
        else $error("nominal clock wrong");
    ref_gate_a: assert property (!seen_r |-> !mod_step && !sample_valid_r)
        else $error("activity before reference settled");
    step_alt_a: assert property (mod_step |-> alt_step_s)
        else $error("step not every second cycle");
    valid_pulse_a: assert property (sample_valid_r |=> !sample_valid_r)
        else $error("valid longer than one cycle");
    valid_after_step_a: assert property (sample_valid_r |-> $past(mod_step, 2))
        else $error("valid not two cycles after a step");
    fast_path_a: assert property (sample_valid_r |-> fast_filter_r == (vcnt_r < 2'h2))
        else $error("filter path wrong");
endmodule : conv_ctrl_checker

bind conv_ctrl conv_ctrl_checker u_chk (.core_clk(core_clk), .rst(rst), .chan_cfg(chan_cfg),
    .power_mode_field(power_mode_field), .ref_settled(ref_settled), .analog_ctrl_r(analog_ctrl_r),
    .bias_mode_r(bias_mode_r), .nominal_mclk_khz_r(nominal_mclk_khz_r), .mod_step(mod_step),
    .sample_valid_r(sample_valid_r), .fast_filter_r(fast_filter_r));

// File: verif/mod_source.sv
// Purpose: Model of the modulators and reference feeding the block
// Assumes: Driven from the master clock
// Notes:   Channels alternate constant ones and constant zeros
module mod_source #(
    parameter int         SETTLE_CYC = 20,
    parameter logic [5:0] PATTERN    = 6'h15
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Analog side
    output logic [5:0]      mod_bits,
    output logic            ref_settled
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt;

    always @(posedge core_clk) begin
        if (rst) begin
            cnt         <= 0;
            ref_settled <= 1'b0;
        end else begin
            cnt         <= cnt + 1;
            ref_settled <= (cnt >= SETTLE_CYC);
        end
        mod_bits <= PATTERN;
    end
endmodule : mod_source

// File: verif/adc_channel_config_decimation_bench.sv
// Purpose: Self-checking bench for the conversion control block
// Assumes: 100 MHz master clock, modulator model with fixed pattern
// Notes:   Ratio codes 6 and 7 are left out to bound run time
module adc_channel_config_decimation_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_pkg::*;

    logic                  core_clk;
    logic                  rst;
    gain_config_register_t chan_cfg;
    logic [1:0]            power_mode_field;
    logic [2:0]            oversampling_ratio_field;
    logic                  ref_settled;
    logic [NUM_CH-1:0]     mod_bits;
    analog_ctrl_t          analog_ctrl_r;
    power_mode_t           bias_mode_r;
    logic [13:0]           nominal_mclk_khz_r;
    logic                  mod_step;
    sample_set_t           samples_r;
    logic                  sample_valid_r;
    logic                  fast_filter_r;
    int                    err_total;
    int                    samples_checked;
    int                    cycle_cnt;

    conv_ctrl u_dut (.core_clk(core_clk), .rst(rst), .chan_cfg(chan_cfg), .power_mode_field(power_mode_field),
        .oversampling_ratio_field(oversampling_ratio_field), .ref_settled(ref_settled), .mod_bits(mod_bits),
        .analog_ctrl_r(analog_ctrl_r), .bias_mode_r(bias_mode_r), .nominal_mclk_khz_r(nominal_mclk_khz_r),
        .mod_step(mod_step), .samples_r(samples_r), .sample_valid_r(sample_valid_r), .fast_filter_r(fast_filter_r));

    mod_source u_src (.core_clk(core_clk), .rst(rst), .mod_bits(mod_bits), .ref_settled(ref_settled));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wait_valid(output int cyc);
        cyc = 0;
        do begin
            @(posedge core_clk);
            #1;
            cyc++;
        end while (sample_valid_r !== 1'b1 && cyc < 20000);
    endtask : wait_valid

    task automatic check_samples();
        for (int ch = 0; ch < NUM_CH; ch += 2) begin
            check(32'(samples_r[ch]), 32'h007fffff);
            check(32'(samples_r[ch + 1]), 32'h00800000);
        end
    endtask : check_samples

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic wait_ref_gate();
        repeat (15) begin
            @(posedge core_clk);
            #1;
            check(32'(mod_step), 32'h0);
        end
    endtask : wait_ref_gate

    task automatic config_sweep();
        gain_config_register_t v;
        logic [2:0]            g;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            for (int k = 0; k < 8; k++) begin
                g = k[2:0];
                v = '0;
                v[ch] = {g[1:0], g};
                @(posedge core_clk);
                chan_cfg <= v;
                repeat (2) @(posedge core_clk);
                #1;
                check(32'(analog_ctrl_r[ch].route_onehot), 32'(4'h1 << g[1:0]));
                check(32'(analog_ctrl_r[ch].precharge_en), 32'(g > 3'h2));
                check(32'(analog_ctrl_r[ch].full_scale_range_uv), 32'(FSR_GAIN_CONFIG_REGISTER_UV >> g));
                check(32'(analog_ctrl_r[(ch + 1) % NUM_CH].full_scale_range_uv), 32'(FSR_GAIN_CONFIG_REGISTER_UV));
            end
        end
    endtask : config_sweep

    task automatic power_sweep();
        logic [13:0] m [4];
        m = '{14'h0800, 14'h1000, 14'h2000, 14'h2000};
        for (int p = 0; p < 4; p++) begin
            @(posedge core_clk);
            power_mode_field <= p[1:0];
            repeat (2) @(posedge core_clk);
            #1;
            check(32'(bias_mode_r), (p == 3) ? 32'h2 : 32'(p));
            check(32'(nominal_mclk_khz_r), 32'(m[p]));
        end
    endtask : power_sweep

    task automatic filter_startup();
        int cyc;
        for (int i = 0; i < 6; i++) begin
            wait_valid(cyc);
            check(32'(fast_filter_r), 32'(i < 2));
            if (i > 0) begin
                check(32'(cyc), 32'h100);
            end
            if (i < 2 || i == 5) begin
                check_samples();
            end
        end
    endtask : filter_startup

    task automatic ratio_sweep();
        int cyc;
        for (int c = 1; c < 6; c++) begin
            @(posedge core_clk);
            oversampling_ratio_field <= c[2:0];
            repeat (4) wait_valid(cyc);
            check(32'(cyc), 32'(2 * (128 << c)));
            check(32'(fast_filter_r), 32'h0);
            check_samples();
        end
    endtask : ratio_sweep

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 90000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        rst                      = 1'b1;
        chan_cfg                 = '0;
        power_mode_field         = 2'h2;
        oversampling_ratio_field = 3'h0;
        err_total                = 0;
        samples_checked          = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        wait_ref_gate();
        filter_startup();
        config_sweep();
        power_sweep();
        ratio_sweep();
        wrap_up();
    end
endmodule : adc_channel_config_decimation_bench
